// *** hw/rtcai_pkg.sv ***
package rtcai_pkg;
   // Register addresses
   localparam logic [3:0] RTCAI_ADDR_MIN_ALARM  = 4'h8;
   localparam logic [3:0] RTCAI_ADDR_HOUR_ALARM = 4'h9;
   localparam logic [3:0] RTCAI_ADDR_WD_ALARM   = 4'hA;
   localparam logic [3:0] RTCAI_ADDR_EXT_CFG    = 4'hD;
   localparam logic [3:0] RTCAI_ADDR_FLAGS      = 4'hE;
   localparam logic [3:0] RTCAI_ADDR_CTRL       = 4'hF;
   // Field positions
   localparam int RTCAI_MASK_BIT     = 7;
   localparam int RTCAI_EXT_UPDATE_PERIOD_SELECT_BIT = 5;
   localparam int RTCAI_EXT_WEEKDAY_DATE_SELECT_BIT = 3;
   localparam int RTCAI_FLG_UF_BIT   = 5;
   localparam int RTCAI_FLG_TF_BIT   = 4;
   localparam int RTCAI_FLG_AF_BIT   = 3;
   localparam int RTCAI_CTL_UIE_BIT  = 5;
   localparam int RTCAI_CTL_TIE_BIT  = 4;
   localparam int RTCAI_CTL_AIE_BIT  = 3;
   localparam int RTCAI_CTL_STOP_BIT = 1;
   // Reset values
   localparam logic [7:0] RTCAI_RST_REG = 8'h00;
   // Writable bit mask of the control register
   localparam logic [7:0] RTCAI_CTL_WMASK = 8'h3E;
   // Timing
   localparam int RTCAI_CLK_HZ        = 100_000_000;
   localparam int RTCAI_UPD_PULSE_US  = 7813;
   localparam int RTCAI_UPD_DELAY_US  = 23440;
   localparam int RTCAI_ALM_DELAY_US  = 1460;
   localparam int RTCAI_UPD_PULSE_CYC =
      (RTCAI_UPD_PULSE_US * (RTCAI_CLK_HZ / 1_000_000));
endpackage : rtcai_pkg

// *** hw/rtcai_alarm_update_irq.sv ***
`timescale 1ns/1ps
// What this block does
// (R1) Alarm match sets the alarm flag; it holds until software writes zero.
// (R2) Zero write clears alarm flag and releases pin; one write does nothing.
// (R3) Alarm enable at one pulls the interrupt pin low on alarm.
// (R4) Alarm enable at zero keeps or returns the pin released.
// (R5) Alarm enable gates only the pin; the flag sets regardless.
// (R6) Select zero: alarm day byte is a weekday bitmap, bit 0 Sunday.
// (R7) Select one: alarm day byte is a BCD day of month.
// (R8) A field with its bit-7 mask set is left out of the compare.
// (R9) Update events every second at select zero, every minute at one.
// (R10) Update-caused low on the pin releases itself after 7.813 ms.
// (R11) Update pulls the pin low within 23.44 ms of the time update.
// (R12) No update events while the clock stop bit is one.
// (R13) Update event sets update flag, held until zero written; one ignored.
// (R14) Writing zero to update flag clears it and releases its pin low.
// (R15) Update enable readable and writable; at zero no update low on pin.
// (R16) Update events continue whatever the update enable says.
// (R17) Software should clear update enable before changing related settings.
// (R18) Alarm flag and pin change within 1.46 ms of the calendar match.
// (R19) No alarm events while the clock stop bit is one.
// (R20) All three masks set: alarm fires once every minute.
// (R21) Timer, update and alarm share one pin; flags tell the source.
// (R22) Pin low while any enabled source is active, released otherwise.
module rtcai_alarm_update_irq
   import rtcai_pkg::*;
#(
   parameter int UPD_PULSE_CYC = RTCAI_UPD_PULSE_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       srst,
   // Register port from the serial bus front end
   input  wire logic       reg_wr,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Calendar from the counting chain, BCD
   input  wire logic       sec_tick,
   input  wire logic       min_tick,
   input  wire logic [6:0] cal_min,
   input  wire logic [5:0] cal_hour,
   input  wire logic [2:0] cal_weekday,
   input  wire logic [5:0] cal_date,
   // Timer event from the fixed-cycle timer
   input  wire logic       timer_event,
   // Open-drain interrupt pin, active low
   output logic            irq_n,
   output logic            irq_n_oe
);
   logic [7:0] alarm_min;
   logic [7:0] alarm_hour;
   logic [7:0] alarm_wd;
   logic [7:0] extension_config;
   logic       alarm_flag;
   logic       update_flag;
   logic       timer_flag;
   logic [7:0] interrupt_control;
   logic       upd_pulse;
   logic [31:0] upd_cnt;
   logic       alm_event;
   logic       upd_event;
   logic       wr_flags;
   logic       wr_ctrl;
   logic       stop;
   logic       next_irq;

   assign stop     = interrupt_control[RTCAI_CTL_STOP_BIT];
   assign wr_flags = reg_wr && (reg_addr == RTCAI_ADDR_FLAGS);
   assign wr_ctrl  = reg_wr && (reg_addr == RTCAI_ADDR_CTRL);

   // Alarm compare on each minute rollover, so a preset equal to now waits
   always_comb begin
      logic m_ok;
      logic h_ok;
      logic d_ok;
      d_ok = 1'b0;
      m_ok = alarm_min[RTCAI_MASK_BIT] ||
             (alarm_min[6:0] == cal_min);                     // [R8]
      h_ok = alarm_hour[RTCAI_MASK_BIT] ||
             (alarm_hour[5:0] == cal_hour);                   // [R8]
      if (alarm_wd[RTCAI_MASK_BIT]) begin
         d_ok = 1'b1;                                         // [R8] [R20]
      end else if (extension_config[RTCAI_EXT_WEEKDAY_DATE_SELECT_BIT]) begin
         d_ok = (alarm_wd[5:0] == cal_date);                  // [R7]
      end else begin
         d_ok = alarm_wd[cal_weekday];                        // [R6]
      end
      alm_event = min_tick && !stop && m_ok && h_ok && d_ok;  // [R19] [R18]
   end

   // Update source: tick choice by period select, blocked while stopped
   assign upd_event = !stop && (extension_config[RTCAI_EXT_UPDATE_PERIOD_SELECT_BIT] ?
                                min_tick : sec_tick); // [R9] [R12] [R16]

   // Configuration and alarm registers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         alarm_min         <= RTCAI_RST_REG;
         alarm_hour        <= RTCAI_RST_REG;
         alarm_wd          <= RTCAI_RST_REG;
         extension_config  <= RTCAI_RST_REG;
         interrupt_control <= RTCAI_RST_REG;
      end else if (reg_wr) begin
         unique case (reg_addr)
            RTCAI_ADDR_MIN_ALARM:  alarm_min        <= reg_wdata;
            RTCAI_ADDR_HOUR_ALARM: alarm_hour       <= reg_wdata;
            RTCAI_ADDR_WD_ALARM:   alarm_wd         <= reg_wdata;
            RTCAI_ADDR_EXT_CFG:    extension_config <= reg_wdata;
            RTCAI_ADDR_CTRL:
               interrupt_control <= reg_wdata & RTCAI_CTL_WMASK; // [R15]
            default: ;
         endcase
      end
   end

   // Sticky flags: a zero write clears, a one write is ignored, set wins
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         alarm_flag  <= 1'b0;
         update_flag <= 1'b0;
         timer_flag  <= 1'b0;
      end else begin
         if (alm_event) begin
            alarm_flag <= 1'b1;                               // [R1] [R5]
         end else if (wr_flags && !reg_wdata[RTCAI_FLG_AF_BIT]) begin
            alarm_flag <= 1'b0;                               // [R2]
         end
         if (upd_event) begin
            update_flag <= 1'b1;                              // [R13]
         end else if (wr_flags && !reg_wdata[RTCAI_FLG_UF_BIT]) begin
            update_flag <= 1'b0;                              // [R14]
         end
         if (timer_event) begin
            timer_flag <= 1'b1;
         end else if (wr_flags && !reg_wdata[RTCAI_FLG_TF_BIT]) begin
            timer_flag <= 1'b0;
         end
      end
   end

   // Update pulse on the pin, self-timed so a missed read does not hang it
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         upd_pulse <= 1'b0;
         upd_cnt   <= 32'h0000_0000;
      end else if (upd_event) begin
         upd_pulse <= 1'b1;
         upd_cnt   <= 32'(UPD_PULSE_CYC - 1);
      end else if (wr_flags && !reg_wdata[RTCAI_FLG_UF_BIT]) begin
         upd_pulse <= 1'b0;                                   // [R14]
      end else if (upd_pulse) begin
         if (upd_cnt == 32'h0000_0000) begin
            upd_pulse <= 1'b0;                                // [R10]
         end else begin
            upd_cnt <= upd_cnt - 32'h0000_0001;
         end
      end
   end

   // Shared pin: any enabled source pulls low
   always_comb begin
      next_irq = 1'b0;                                        // [R22]
      if (alarm_flag && interrupt_control[RTCAI_CTL_AIE_BIT]) begin
         next_irq = 1'b1;                                     // [R3] [R4]
      end
      if (upd_pulse && interrupt_control[RTCAI_CTL_UIE_BIT]) begin
         next_irq = 1'b1;                                     // [R15]
      end
      if (timer_flag && interrupt_control[RTCAI_CTL_TIE_BIT]) begin
         next_irq = 1'b1;                                     // [R21] [R22]
      end
   end

   // Pin register; data stays low, the enable does the driving
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_n_oe <= 1'b0;
         irq_n    <= 1'b0;
      end else begin
         irq_n_oe <= next_irq;                                // [R11] [R22]
         irq_n    <= 1'b0;
      end
   end

   // Readback, registered; unmapped addresses read zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata <= RTCAI_RST_REG;
      end else begin
         unique case (reg_addr)
            RTCAI_ADDR_MIN_ALARM:  reg_rdata <= alarm_min;
            RTCAI_ADDR_HOUR_ALARM: reg_rdata <= alarm_hour;
            RTCAI_ADDR_WD_ALARM:   reg_rdata <= alarm_wd;
            RTCAI_ADDR_EXT_CFG:    reg_rdata <= extension_config;
            RTCAI_ADDR_FLAGS:
               reg_rdata <= {2'b00, update_flag, timer_flag,
                             alarm_flag, 3'b000};             // [R21]
            RTCAI_ADDR_CTRL:       reg_rdata <= interrupt_control;
            default:               reg_rdata <= RTCAI_RST_REG;
         endcase
      end
   end

   // Checks
   property p_af_set;
      @(posedge sys_clk) disable iff (srst)
      alm_event |=> alarm_flag;
   endproperty
   a_af_set: assert property (p_af_set)                       // [R1]
      else $error("alarm flag not set after match");

   property p_af_one_write;
      @(posedge sys_clk) disable iff (srst)
      (alarm_flag && wr_flags && reg_wdata[RTCAI_FLG_AF_BIT]) |=> alarm_flag;
   endproperty
   a_af_one_write: assert property (p_af_one_write)           // [R2]
      else $error("writing one changed alarm flag");

   property p_af_clear;
      @(posedge sys_clk) disable iff (srst)
      (wr_flags && !reg_wdata[RTCAI_FLG_AF_BIT] && !alm_event) |=> !alarm_flag;
   endproperty
   a_af_clear: assert property (p_af_clear)                   // [R2]
      else $error("alarm flag not cleared by zero");

   property p_alarm_pin;
      @(posedge sys_clk) disable iff (srst)
      (alarm_flag && interrupt_control[RTCAI_CTL_AIE_BIT]) |=> irq_n_oe;
   endproperty
   a_alarm_pin: assert property (p_alarm_pin)                 // [R3]
      else $error("alarm did not pull pin low");

   property p_pin_idle;
      @(posedge sys_clk) disable iff (srst)
      (!interrupt_control[RTCAI_CTL_AIE_BIT] &&
       !interrupt_control[RTCAI_CTL_UIE_BIT] &&
       !interrupt_control[RTCAI_CTL_TIE_BIT]) |=> !irq_n_oe;
   endproperty
   a_pin_idle: assert property (p_pin_idle)                   // [R4]
      else $error("pin driven with all enables clear");

   property p_stop_quiet;
      @(posedge sys_clk) disable iff (srst)
      (stop && !update_flag && !wr_flags) |=> !update_flag;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)               // [R12]
      else $error("update flag set while stopped");

   property p_upd_set;
      @(posedge sys_clk) disable iff (srst)
      upd_event |=> (update_flag && upd_pulse);
   endproperty
   a_upd_set: assert property (p_upd_set)                     // [R13]
      else $error("update event lost");

   property p_upd_pulse_len;
      @(posedge sys_clk) disable iff (srst)
      $rose(upd_pulse) |-> (upd_cnt == 32'(UPD_PULSE_CYC - 1));
   endproperty
   a_upd_pulse_len: assert property (p_upd_pulse_len)         // [R10]
      else $error("update pulse length wrong");

   property p_af_hold;
      @(posedge sys_clk) disable iff (srst)
      (alarm_flag && !(wr_flags && !reg_wdata[RTCAI_FLG_AF_BIT]))
      |=> alarm_flag;
   endproperty
   a_af_hold: assert property (p_af_hold)                     // [R1]
      else $error("alarm flag dropped without zero write");

   property p_stop_no_alarm;
      @(posedge sys_clk) disable iff (srst)
      (stop && !alarm_flag) |=> !alarm_flag;
   endproperty
   a_stop_no_alarm: assert property (p_stop_no_alarm)         // [R19]
      else $error("alarm flag set while stopped");

   property p_alarm_gate;
      @(posedge sys_clk) disable iff (srst)
      (!interrupt_control[RTCAI_CTL_AIE_BIT] &&
       !(upd_pulse && interrupt_control[RTCAI_CTL_UIE_BIT]) &&
       !(timer_flag && interrupt_control[RTCAI_CTL_TIE_BIT])) |=> !irq_n_oe;
   endproperty
   a_alarm_gate: assert property (p_alarm_gate)               // [R4]
      else $error("alarm drove pin with its enable clear");

   property p_upd_release;
      @(posedge sys_clk) disable iff (srst)
      (upd_pulse && upd_cnt == 32'h0000_0000 && !upd_event) |=> !upd_pulse;
   endproperty
   a_upd_release: assert property (p_upd_release)             // [R10]
      else $error("update pulse outlived its count");

   property p_upd_count;
      @(posedge sys_clk) disable iff (srst)
      (upd_pulse && upd_cnt != 32'h0000_0000 && !upd_event && !wr_flags)
      |=> (upd_pulse && upd_cnt == $past(upd_cnt) - 32'h0000_0001);
   endproperty
   a_upd_count: assert property (p_upd_count)                 // [R10]
      else $error("update pulse count skipped");

   property p_upd_clear;
      @(posedge sys_clk) disable iff (srst)
      (wr_flags && !reg_wdata[RTCAI_FLG_UF_BIT] && !upd_event)
      |=> (!update_flag && !upd_pulse);
   endproperty
   a_upd_clear: assert property (p_upd_clear)                 // [R14]
      else $error("update flag or pulse kept after zero write");

   property p_upd_pin;
      @(posedge sys_clk) disable iff (srst)
      (upd_pulse && interrupt_control[RTCAI_CTL_UIE_BIT]) |=> irq_n_oe;
   endproperty
   a_upd_pin: assert property (p_upd_pin)                     // [R11]
      else $error("update did not pull pin low");

   property p_upd_gate;
      @(posedge sys_clk) disable iff (srst)
      (!interrupt_control[RTCAI_CTL_UIE_BIT] &&
       !(alarm_flag && interrupt_control[RTCAI_CTL_AIE_BIT]) &&
       !(timer_flag && interrupt_control[RTCAI_CTL_TIE_BIT])) |=> !irq_n_oe;
   endproperty
   a_upd_gate: assert property (p_upd_gate)                   // [R15]
      else $error("update drove pin with its enable clear");
endmodule : rtcai_alarm_update_irq

// *** sim/rtcai_host_model.sv ***
`timescale 1ns/1ps
// Host end of the shared open-drain line, with its pull-up
module rtcai_host_model (
   input  wire logic irq_n,
   input  wire logic irq_n_oe,
   output logic      irq_line_n
);
   // Released line floats up to high, never holds the last level
   assign irq_line_n = irq_n_oe ? irq_n : 1'b1;
endmodule : rtcai_host_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   import rtcai_pkg::*;
   logic       sys_clk, srst, reg_wr, sec_tick, min_tick, timer_event;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [6:0] cal_min;
   logic [5:0] cal_hour, cal_date;
   logic [2:0] cal_weekday;
   logic       irq_n, irq_n_oe, irq_line_n;
   int         n_errors = 0;
   int         total_checks = 0;

   localparam int UPD_CYC = 20;

   // Short pulse so the self-release shows up quickly
   rtcai_alarm_update_irq #(.UPD_PULSE_CYC(UPD_CYC)) i_dut (
      .sys_clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
      .sec_tick, .min_tick, .cal_min, .cal_hour, .cal_weekday,
      .cal_date, .timer_event, .irq_n, .irq_n_oe);
   rtcai_host_model i_host (.irq_n, .irq_n_oe, .irq_line_n);

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: saw %h want %h", $time, got, exp);
      end
   endtask : chk

   // All drivers start and end on a falling edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      @(negedge sys_clk); // Idle cycle keeps back-to-back strobes apart
   endtask : wr

   // Read data is registered, so wait two edges
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      reg_addr = a;
      repeat (2) @(negedge sys_clk);
      chk(reg_rdata, e);
   endtask : rd

   task automatic flg(input logic [7:0] e);
      rd(RTCAI_ADDR_FLAGS, e);
   endtask : flg

   // Pin follows its cause one edge later
   task automatic pin(input logic e);
      @(negedge sys_clk);
      chk({7'h00, irq_line_n}, {7'h00, e});
   endtask : pin

   // One-cycle event pulses, then flag and pin have settled
   task automatic ev(input logic s, input logic m, input logic t);
      sec_tick = s;
      min_tick = m;
      timer_event = t;
      @(negedge sys_clk);
      sec_tick = 1'b0;
      min_tick = 1'b0;
      timer_event = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask : ev

   task automatic t_reset();
      flg(RTCAI_RST_REG);
      rd(RTCAI_ADDR_EXT_CFG, RTCAI_RST_REG);
      pin(1'b1);
      wr(RTCAI_ADDR_CTRL, 8'hFF);
      rd(RTCAI_ADDR_CTRL, RTCAI_CTL_WMASK);
      wr(RTCAI_ADDR_CTRL, 8'h00);
   endtask : t_reset

   // Weekday match, set-only flag, enable gating the pin
   task automatic t_alarm();
      wr(RTCAI_ADDR_MIN_ALARM, 8'h30);
      wr(RTCAI_ADDR_HOUR_ALARM, 8'h12);
      wr(RTCAI_ADDR_WD_ALARM, 8'h02);
      wr(RTCAI_ADDR_CTRL, 8'h08);
      ev(1'b1, 1'b1, 1'b0);
      pin(1'b0);
      flg(8'h28);
      wr(RTCAI_ADDR_FLAGS, 8'hFF);
      flg(8'h28);
      wr(RTCAI_ADDR_CTRL, 8'h00);
      pin(1'b1);
      flg(8'h28);
      wr(RTCAI_ADDR_CTRL, 8'h08);
      pin(1'b0);
      wr(RTCAI_ADDR_FLAGS, 8'h00);
      pin(1'b1);
   endtask : t_alarm

   // Date compare, masks, and the stop bit
   task automatic t_mask();
      wr(RTCAI_ADDR_EXT_CFG, 8'h08);
      wr(RTCAI_ADDR_WD_ALARM, 8'h15);
      wr(RTCAI_ADDR_CTRL, 8'h00);
      ev(1'b1, 1'b1, 1'b0);
      pin(1'b1);
      flg(8'h28);
      wr(RTCAI_ADDR_FLAGS, 8'h00);
      wr(RTCAI_ADDR_WD_ALARM, 8'h16);
      ev(1'b1, 1'b1, 1'b0);
      flg(8'h20);
      wr(RTCAI_ADDR_MIN_ALARM, 8'hD9);
      wr(RTCAI_ADDR_HOUR_ALARM, 8'h80);
      wr(RTCAI_ADDR_WD_ALARM, 8'h80);
      ev(1'b1, 1'b1, 1'b0);
      flg(8'h28);
      wr(RTCAI_ADDR_FLAGS, 8'h00);
      wr(RTCAI_ADDR_CTRL, 8'h02);
      ev(1'b1, 1'b1, 1'b0);
      flg(8'h00);
      wr(RTCAI_ADDR_MIN_ALARM, 8'h59);
   endtask : t_mask

   // Update pulse, period select, enable, and the timer source
   task automatic t_update();
      wr(RTCAI_ADDR_EXT_CFG, 8'h00);
      wr(RTCAI_ADDR_CTRL, 8'h20);
      ev(1'b1, 1'b0, 1'b0);
      pin(1'b0);
      flg(8'h20);
      // Pin stands low exactly UPD_CYC cycles: see its last and first edge
      repeat (UPD_CYC - 6) @(negedge sys_clk);
      pin(1'b0);
      pin(1'b1);
      wr(RTCAI_ADDR_FLAGS, 8'h20);
      flg(8'h20);
      wr(RTCAI_ADDR_FLAGS, 8'h00);
      wr(RTCAI_ADDR_CTRL, 8'h00);
      wr(RTCAI_ADDR_EXT_CFG, 8'h20);
      wr(RTCAI_ADDR_CTRL, 8'h20);
      ev(1'b1, 1'b0, 1'b0);
      flg(8'h00);
      ev(1'b1, 1'b1, 1'b0);
      pin(1'b0);
      rd(RTCAI_ADDR_CTRL, 8'h20);
      wr(RTCAI_ADDR_CTRL, 8'h00);
      pin(1'b1);
      flg(8'h20);
      wr(RTCAI_ADDR_CTRL, 8'h30);
      ev(1'b1, 1'b1, 1'b1);
      pin(1'b0);
      flg(8'h30);
      wr(RTCAI_ADDR_FLAGS, 8'h00);
      pin(1'b1);
   endtask : t_update

   task automatic final_report();
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Calendar stands at Monday the 15th, 12:30
   initial begin
      srst = 1'b1;
      {reg_wr, sec_tick, min_tick, timer_event} = 4'h0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      {cal_min, cal_hour, cal_date, cal_weekday} = {7'h30, 6'h12, 6'h15, 3'h1};
      repeat (4) @(negedge sys_clk);
      srst = 1'b0;
      t_reset();
      t_alarm();
      t_mask();
      t_update();
      final_report();
   end

   // Hang guard, far beyond the roughly 150 cycles needed
   initial begin
      #200000;
      n_errors++;
      final_report();
   end
endmodule : testbench
